/* File: hw/gpm_port_regs.v */
`include "gpm_defines.vh"

module gpm_port_regs (
	input  wire        clk,
	input  wire        nrst,
	input  wire [15:0] addr,
	input  wire        byteWrite,
	input  wire        bitWrite,
	input  wire [2:0]  bitSel,
	input  wire        bitVal,
	input  wire [7:0]  wrData,
	input  wire        rdEn,
	output reg  [7:0]  rdData,
	input  wire        mainOscPinsUsed,
	input  wire        mainExtClkMode,
	input  wire        subOscPinsUsed,
	input  wire        subExtClkMode,
	input  wire [6:0]  port0PinIn,
	output wire [6:0]  port0PinOut,
	output wire [6:0]  port0PinOeN,
	output wire [6:0]  port0PullUp,
	input  wire [7:0]  port1PinIn,
	output wire [7:0]  port1PinOut,
	output wire [7:0]  port1PinOeN,
	output wire [7:0]  port1PullUp,
	input  wire [7:0]  port2PinIn,
	output wire [7:0]  port2PinOut,
	output wire [7:0]  port2PinOeN,
	input  wire [3:0]  port3PinIn,
	output wire [3:0]  port3PinOut,
	output wire [3:0]  port3PinOeN,
	output wire [3:0]  port3PullUp,
	input  wire [1:0]  port6PinIn,
	output wire [1:0]  port6PinOut,
	output wire [1:0]  port6PinOeN,
	input  wire [7:0]  port7PinIn,
	output wire [7:0]  port7PinOut,
	output wire [7:0]  port7PinOeN,
	output wire [7:0]  port7PullUp,
	input  wire [4:0]  port12PinIn,
	output wire [4:0]  port12PinOut,
	output wire [4:0]  port12PinOeN,
	output wire [4:0]  port12PullUp,
	output wire [1:0]  port14Direction
);
	function hit;
		input [15:0] a;
		input [15:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	wire       anyWrite;
	wire [7:0] mergedData;
	reg  [7:0] curRead;
	wire [7:0] clk12Mask;
	wire [7:0] zero12Mask;

	wire [7:0] d0, d1, d2, d3, d6, d7, d12, d14;
	wire [7:0] m0, m1, m2, m3, m6, m7, m12, m14;
	wire [7:0] u0, u1, u2, u3, u6, u7, u12, u14;
	wire [7:0] o0, o1, o2, o3, o6, o7, o12, o14;
	wire [7:0] e0, e1, e2, e3, e6, e7, e12, e14;
	wire [7:0] q0, q1, q2, q3, q6, q7, q12, q14;

	// both access widths share one write path
	assign anyWrite = byteWrite | bitWrite;

	// clock pins leave port use; ext clock reads zero
	assign clk12Mask  = (mainOscPinsUsed ? `GPM_MAIN_OSC_BITS : 8'h00)
	                  | (subOscPinsUsed ? `GPM_SUB_OSC_BITS : 8'h00);
	assign zero12Mask = (mainExtClkMode ? `GPM_MAIN_OSC_BITS : 8'h00)
	                  | (subExtClkMode ? `GPM_SUB_OSC_BITS : 8'h00);

	// Current value of the addressed register, also feeds bit writes
	always @* begin
		if (hit(addr, `GPM_ADDR_DATA_0)) begin
			curRead = d0;
		end else if (hit(addr, `GPM_ADDR_DATA_1)) begin
			curRead = d1;
		end else if (hit(addr, `GPM_ADDR_DATA_2)) begin
			curRead = d2;
		end else if (hit(addr, `GPM_ADDR_DATA_3)) begin
			curRead = d3;
		end else if (hit(addr, `GPM_ADDR_DATA_6)) begin
			curRead = d6;
		end else if (hit(addr, `GPM_ADDR_DATA_7)) begin
			curRead = d7;
		end else if (hit(addr, `GPM_ADDR_DATA_12)) begin
			curRead = d12;
		end else if (hit(addr, `GPM_ADDR_DIR_0)) begin
			curRead = m0;
		end else if (hit(addr, `GPM_ADDR_DIR_1)) begin
			curRead = m1;
		end else if (hit(addr, `GPM_ADDR_DIR_2)) begin
			curRead = m2;
		end else if (hit(addr, `GPM_ADDR_DIR_3)) begin
			curRead = m3;
		end else if (hit(addr, `GPM_ADDR_DIR_6)) begin
			curRead = m6;
		end else if (hit(addr, `GPM_ADDR_DIR_7)) begin
			curRead = m7;
		end else if (hit(addr, `GPM_ADDR_DIR_12)) begin
			curRead = m12;
		end else if (hit(addr, `GPM_ADDR_DIR_14)) begin
			curRead = m14;
		end else if (hit(addr, `GPM_ADDR_PU_0)) begin
			curRead = u0;
		end else if (hit(addr, `GPM_ADDR_PU_1)) begin
			curRead = u1;
		end else if (hit(addr, `GPM_ADDR_PU_3)) begin
			curRead = u3;
		end else if (hit(addr, `GPM_ADDR_PU_7)) begin
			curRead = u7;
		end else if (hit(addr, `GPM_ADDR_PU_12)) begin
			curRead = u12;
		end else begin
			curRead = 8'h00;
		end
	end

	// Read data is registered; unmapped addresses return zero
	always @(posedge clk) begin
		if (!nrst) begin
			rdData <= 8'h00;
		end else if (rdEn) begin
			rdData <= curRead;
		end
	end

	// input-mode bits take the pin level back into the latch
	gpm_bit_merge uMerge (
		.bitWrite    (bitWrite),
		.bitSel      (bitSel),
		.bitVal      (bitVal),
		.byteData    (wrData),
		.currentRead (curRead),
		.mergedData  (mergedData)
	);

	gpm_port #(.IMPL(`GPM_IMPL_0), .PU_MASK(8'hff), .OPEN_DRAIN(0)) uP0 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (anyWrite & hit(addr, `GPM_ADDR_DATA_0)),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_0)),
		.puWr         (anyWrite & hit(addr, `GPM_ADDR_PU_0)),
		.wrByte       (mergedData),
		.pinIn        ({1'b0, port0PinIn}),
		.clkPinMask   (8'h00),
		.zeroReadMask (8'h00),
		.dataRead     (d0),
		.dirRead      (m0),
		.puRead       (u0),
		.pinOut       (o0),
		.pinOeN       (e0),
		.pullUpEn     (q0)
	);

	gpm_port #(.IMPL(`GPM_IMPL_1), .PU_MASK(8'hff), .OPEN_DRAIN(0)) uP1 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (anyWrite & hit(addr, `GPM_ADDR_DATA_1)),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_1)),
		.puWr         (anyWrite & hit(addr, `GPM_ADDR_PU_1)),
		.wrByte       (mergedData),
		.pinIn        (port1PinIn),
		.clkPinMask   (8'h00),
		.zeroReadMask (8'h00),
		.dataRead     (d1),
		.dirRead      (m1),
		.puRead       (u1),
		.pinOut       (o1),
		.pinOeN       (e1),
		.pullUpEn     (q1)
	);

	// Port 2 has no pull-up register
	gpm_port #(.IMPL(`GPM_IMPL_2), .PU_MASK(8'h00), .OPEN_DRAIN(0)) uP2 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (anyWrite & hit(addr, `GPM_ADDR_DATA_2)),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_2)),
		.puWr         (1'b0),
		.wrByte       (mergedData),
		.pinIn        (port2PinIn),
		.clkPinMask   (8'h00),
		.zeroReadMask (8'h00),
		.dataRead     (d2),
		.dirRead      (m2),
		.puRead       (u2),
		.pinOut       (o2),
		.pinOeN       (e2),
		.pullUpEn     (q2)
	);

	gpm_port #(.IMPL(`GPM_IMPL_3), .PU_MASK(8'hff), .OPEN_DRAIN(0)) uP3 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (anyWrite & hit(addr, `GPM_ADDR_DATA_3)),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_3)),
		.puWr         (anyWrite & hit(addr, `GPM_ADDR_PU_3)),
		.wrByte       (mergedData),
		.pinIn        ({4'h0, port3PinIn}),
		.clkPinMask   (8'h00),
		.zeroReadMask (8'h00),
		.dataRead     (d3),
		.dirRead      (m3),
		.puRead       (u3),
		.pinOut       (o3),
		.pinOeN       (e3),
		.pullUpEn     (q3)
	);

	// port 6 bit 2 stays an input until software clears it
	gpm_port #(.IMPL(`GPM_IMPL_6), .PU_MASK(8'h00), .OPEN_DRAIN(1)) uP6 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (anyWrite & hit(addr, `GPM_ADDR_DATA_6)),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_6)),
		.puWr         (1'b0),
		.wrByte       (mergedData),
		.pinIn        ({6'h00, port6PinIn}),
		.clkPinMask   (8'h00),
		// No pin behind bit 2: only its direction bit is real
		.zeroReadMask (8'h04),
		.dataRead     (d6),
		.dirRead      (m6),
		.puRead       (u6),
		.pinOut       (o6),
		.pinOeN       (e6),
		.pullUpEn     (q6)
	);

	// eight latched bits, per-bit pull-ups, reset input
	gpm_port #(.IMPL(`GPM_IMPL_7), .PU_MASK(8'hff), .OPEN_DRAIN(0)) uP7 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (anyWrite & hit(addr, `GPM_ADDR_DATA_7)),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_7)),
		.puWr         (anyWrite & hit(addr, `GPM_ADDR_PU_7)),
		.wrByte       (mergedData),
		.pinIn        (port7PinIn),
		.clkPinMask   (8'h00),
		.zeroReadMask (8'h00),
		.dataRead     (d7),
		.dirRead      (m7),
		.puRead       (u7),
		.pinOut       (o7),
		.pinOeN       (e7),
		.pullUpEn     (q7)
	);

	// five bits, pull-up on bit 0 only, reset input
	gpm_port #(.IMPL(`GPM_IMPL_12), .PU_MASK(`GPM_PU_MASK_12),
		.OPEN_DRAIN(0)) uP12 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (anyWrite & hit(addr, `GPM_ADDR_DATA_12)),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_12)),
		.puWr         (anyWrite & hit(addr, `GPM_ADDR_PU_12)),
		.wrByte       (mergedData),
		.pinIn        ({3'h0, port12PinIn}),
		.clkPinMask   (clk12Mask),
		.zeroReadMask (zero12Mask),
		.dataRead     (d12),
		.dirRead      (m12),
		.puRead       (u12),
		.pinOut       (o12),
		.pinOeN       (e12),
		.pullUpEn     (q12)
	);

	// Port 14 exposes only its direction here; its pins live elsewhere
	gpm_port #(.IMPL(`GPM_IMPL_14), .PU_MASK(8'h00), .OPEN_DRAIN(0)) uP14 (
		.clk          (clk),
		.nrst         (nrst),
		.dataWr       (1'b0),
		.dirWr        (anyWrite & hit(addr, `GPM_ADDR_DIR_14)),
		.puWr         (1'b0),
		.wrByte       (mergedData),
		.pinIn        (8'h00),
		.clkPinMask   (8'h00),
		.zeroReadMask (8'h00),
		.dataRead     (d14),
		.dirRead      (m14),
		.puRead       (u14),
		.pinOut       (o14),
		.pinOeN       (e14),
		.pullUpEn     (q14)
	);

	assign port0PinOut     = o0[6:0];
	assign port0PinOeN     = e0[6:0];
	assign port0PullUp     = q0[6:0];
	assign port1PinOut     = o1;
	assign port1PinOeN     = e1;
	assign port1PullUp     = q1;
	assign port2PinOut     = o2;
	assign port2PinOeN     = e2;
	assign port3PinOut     = o3[3:0];
	assign port3PinOeN     = e3[3:0];
	assign port3PullUp     = q3[3:0];
	assign port6PinOut     = o6[1:0];
	assign port6PinOeN     = e6[1:0];
	assign port7PinOut     = o7;
	assign port7PinOeN     = e7;
	assign port7PullUp     = q7;
	assign port12PinOut    = o12[4:0];
	assign port12PinOeN    = e12[4:0];
	assign port12PullUp    = q12[4:0];
	assign port14Direction = m14[1:0];
endmodule

/* File: hw/gpm_defines.vh */
// Summary of operation
// - Port 7: eight latched bits, per-bit direction
// - Port 7 input bits get selectable pull-ups
// - Reset puts all port 7 bits in input
// - Port 12: five latched bits, per-bit direction
// - Only port 12 bit 0 has a pull-up
// - Reset puts all port 12 bits in input
// - Oscillator modes take port 12 pins 1-4
// - One direction bit per pin, bit by bit
// - Direction 0 drives output, 1 is input
// - Direction registers reset to all ones
// - Single-bit and whole-byte writes both accepted
// - Data read: pin if input, latch if output
// - Latch 0 drives low, 1 drives high, except open-drain port 6 where 1 releases the pin
// - Reset clears every output latch
// - External clock pins read latch as zero
// - No pull-up on output-mode pins
// - Bit write is a full byte read-modify-write
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH

`define GPM_ADDR_DATA_0   16'hff00
`define GPM_ADDR_DATA_1   16'hff01
`define GPM_ADDR_DATA_2   16'hff02
`define GPM_ADDR_DATA_3   16'hff03
`define GPM_ADDR_DATA_6   16'hff06
`define GPM_ADDR_DATA_7   16'hff07
`define GPM_ADDR_DATA_12  16'hff0c
`define GPM_ADDR_DIR_0    16'hff20
`define GPM_ADDR_DIR_1    16'hff21
`define GPM_ADDR_DIR_2    16'hff22
`define GPM_ADDR_DIR_3    16'hff23
`define GPM_ADDR_DIR_6    16'hff26
`define GPM_ADDR_DIR_7    16'hff27
`define GPM_ADDR_DIR_12   16'hff2c
`define GPM_ADDR_DIR_14   16'hff2e
`define GPM_ADDR_PU_0     16'hff30
`define GPM_ADDR_PU_1     16'hff31
`define GPM_ADDR_PU_3     16'hff33
`define GPM_ADDR_PU_7     16'hff37
`define GPM_ADDR_PU_12    16'hff3c

`define GPM_RST_DATA      8'h00
`define GPM_RST_DIR       8'hff
`define GPM_RST_PU        8'h00

`define GPM_IMPL_0        8'h7f
`define GPM_IMPL_1        8'hff
`define GPM_IMPL_2        8'hff
`define GPM_IMPL_3        8'h0f
`define GPM_IMPL_6        8'h07
`define GPM_IMPL_7        8'hff
`define GPM_IMPL_12       8'h1f
`define GPM_IMPL_14       8'h03

`define GPM_PU_MASK_12    8'h01
`define GPM_MAIN_OSC_BITS 8'h06
`define GPM_SUB_OSC_BITS  8'h18

`endif

/* File: hw/gpm_bit_merge.v */
module gpm_bit_merge (
	input  wire       bitWrite,
	input  wire [2:0] bitSel,
	input  wire       bitVal,
	input  wire [7:0] byteData,
	input  wire [7:0] currentRead,
	output reg  [7:0] mergedData
);
	reg [7:0] sel;

	always @* begin
		sel = 8'h01 << bitSel;
		if (bitWrite) begin
			mergedData = (currentRead & ~sel) | (bitVal ? sel : 8'h00);
		end else begin
			mergedData = byteData;
		end
	end
endmodule

/* File: hw/gpm_port.v */
`include "gpm_defines.vh"

module gpm_port #(
	parameter [7:0] IMPL       = 8'hff,
	parameter [7:0] PU_MASK    = 8'hff,
	parameter       OPEN_DRAIN = 0
) (
	input  wire       clk,
	input  wire       nrst,
	input  wire       dataWr,
	input  wire       dirWr,
	input  wire       puWr,
	input  wire [7:0] wrByte,
	input  wire [7:0] pinIn,
	input  wire [7:0] clkPinMask,
	input  wire [7:0] zeroReadMask,
	output wire [7:0] dataRead,
	output wire [7:0] dirRead,
	output wire [7:0] puRead,
	output wire [7:0] pinOut,
	output wire [7:0] pinOeN,
	output wire [7:0] pullUpEn
);
	reg  [7:0] latch_reg;
	reg  [7:0] dir_reg;
	reg  [7:0] pu_reg;
	wire [7:0] outMode;

	always @(posedge clk) begin
		if (!nrst) begin
			latch_reg <= `GPM_RST_DATA;
			dir_reg   <= `GPM_RST_DIR;
			pu_reg    <= `GPM_RST_PU;
		end else begin
			if (dataWr) begin
				latch_reg <= wrByte & IMPL;
			end
			if (dirWr) begin
				dir_reg <= wrByte | ~IMPL;
			end
			if (puWr) begin
				pu_reg <= wrByte & IMPL & PU_MASK;
			end
		end
	end

	// zero enables the buffer; clock pins are never driven
	assign outMode = ~dir_reg & IMPL & ~clkPinMask;
	assign pinOut  = (OPEN_DRAIN != 0) ? 8'h00 : latch_reg;
	// Open-drain bits only pull low, a latched one releases the pin
	assign pinOeN  = (OPEN_DRAIN != 0) ? ~(outMode & ~latch_reg)
	                                   : ~outMode;
	assign pullUpEn = pu_reg & dir_reg & IMPL & PU_MASK & ~clkPinMask;
	// pin in input, latch in output; external-clock pins read 0
	assign dataRead = ((dir_reg & pinIn) | (~dir_reg & latch_reg))
	                  & IMPL & ~zeroReadMask;
	assign dirRead  = dir_reg | ~IMPL;
	assign puRead   = pu_reg;
endmodule

/* File: tb/gpm_checker_properties.sv */
module gpm_checker (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [15:0] addr,
	input wire logic        byteWrite,
	input wire logic        bitWrite,
	input wire logic [7:0]  wrData,
	input wire logic        rdEn,
	input wire logic [7:0]  rdData,
	input wire logic        mainOscPinsUsed,
	input wire logic        mainExtClkMode,
	input wire logic [7:0]  port7PinOut,
	input wire logic [7:0]  port7PinOeN,
	input wire logic [7:0]  port7PullUp,
	input wire logic [4:0]  port12PinOeN,
	input wire logic [4:0]  port12PullUp
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	wire logic wrIdle = !byteWrite && !bitWrite;
	a_reset_state: assert property (disable iff (1'b0)
		!nrst |=> port7PinOeN == 8'hff && port12PinOeN == 5'h1f
		&& port7PinOut == 8'h00) else $error("bad reset state");
	a_dir_drives: assert property (byteWrite && !bitWrite
		&& addr == 16'hff27 |=> port7PinOeN == $past(wrData))
		else $error("direction write lost");
	a_latch_drives: assert property (byteWrite && !bitWrite
		&& addr == 16'hff07 |=> port7PinOut == $past(wrData))
		else $error("latch write lost");
	a_no_pull_out: assert property ((port7PullUp & ~port7PinOeN)
		== 8'h00 && (port12PullUp & ~port12PinOeN) == 5'h00)
		else $error("pull-up on driven pin");
	a_p12_pull_bit0: assert property (port12PullUp[4:1] == 4'h0)
		else $error("pull-up above bit 0");
	a_read_latch: assert property (rdEn && wrIdle
		&& addr == 16'hff07 |=> (rdData & ~$past(port7PinOeN))
		== ($past(port7PinOut) & ~$past(port7PinOeN)))
		else $error("output bit not read from latch");
	a_ext_clk_zero: assert property (rdEn && mainExtClkMode
		&& addr == 16'hff0c |=> rdData[2:1] == 2'h0)
		else $error("clock pins read nonzero");
	a_osc_no_drive: assert property (mainOscPinsUsed
		|-> port12PinOeN[2:1] == 2'h3) else $error("clock pin driven");
	a_dir_unimpl: assert property (rdEn && addr == 16'hff2c
		|=> rdData[7:5] == 3'h7) else $error("bad unused bits");
	a_read_hold: assert property (!rdEn |=> $stable(rdData))
		else $error("read data moved");
endmodule

bind gpm_port_regs gpm_checker u_chk (.clk, .nrst, .addr, .byteWrite,
	.bitWrite, .wrData, .rdEn, .rdData, .mainOscPinsUsed, .mainExtClkMode,
	.port7PinOut, .port7PinOeN, .port7PullUp, .port12PinOeN, .port12PullUp);

/* File: tb/gpm_pin_model.sv */
module gpm_pin_model #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] pinOut,
	input  wire logic [W-1:0] pinOeN,
	input  wire logic [W-1:0] pullUp,
	input  wire logic [W-1:0] extLvl,
	input  wire logic [W-1:0] extEn,
	output logic      [W-1:0] pinIn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [W-1:0] lastLvl;
	// pull-up on undriven bits
	// A floating line flips each cycle so stale values never pass
	assign pinIn = (~pinOeN & pinOut) | (pinOeN & extEn & extLvl)
		| (pinOeN & ~extEn & (pullUp | ~lastLvl));
	always @(posedge clk) lastLvl <= pinIn;
endmodule

/* File: tb/gpm_port_regs_test.sv */
module gpm_port_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'h0, nrst = 1'h0, bitVal = 1'h0, rdEn = 1'h0;
	logic        byteWrite = 1'h0, bitWrite = 1'h0;
	logic        mOsc = 1'h0, mExt = 1'h0, sOsc = 1'h0, sExt = 1'h0;
	logic [15:0] addr = 16'h0;
	logic [2:0]  bitSel = 3'h0;
	logic [7:0]  wrData = 8'h0, rdData, p7Out, p7OeN, p7Pu, p7In;
	logic [7:0]  p7Ext = 8'h5a, p7En = 8'hff;
	logic [7:0]  p1In = 8'ha3, p2In = 8'h3c;
	logic [4:0]  p12Out, p12OeN, p12Pu, p12In;
	logic [4:0]  p12Ext = 5'h0a, p12En = 5'h1f;
	logic [1:0]  p14Dir;
	logic [15:0] dirA [8] = '{16'hff20, 16'hff21, 16'hff22, 16'hff23,
		16'hff26, 16'hff27, 16'hff2c, 16'hff2e};
	int          miscompares = 0, num_checks = 0;

	always #25 clk = ~clk;

	gpm_port_regs u_dut (.clk, .nrst, .addr, .byteWrite, .bitWrite, .bitSel,
		.bitVal, .wrData, .rdEn, .rdData, .mainOscPinsUsed(mOsc),
		.mainExtClkMode(mExt), .subOscPinsUsed(sOsc), .subExtClkMode(sExt),
		.port0PinIn(7'h0), .port0PinOut(), .port0PinOeN(), .port0PullUp(),
		.port1PinIn(p1In), .port1PinOut(), .port1PinOeN(), .port1PullUp(),
		.port2PinIn(p2In), .port2PinOut(), .port2PinOeN(),
		.port3PinIn(4'h0), .port3PinOut(), .port3PinOeN(), .port3PullUp(),
		.port6PinIn(2'h0), .port6PinOut(), .port6PinOeN(),
		.port7PinIn(p7In), .port7PinOut(p7Out), .port7PinOeN(p7OeN),
		.port7PullUp(p7Pu), .port12PinIn(p12In), .port12PinOut(p12Out),
		.port12PinOeN(p12OeN), .port12PullUp(p12Pu), .port14Direction(p14Dir));
	gpm_pin_model #(.W(8)) u_pins7 (.clk, .pinOut(p7Out), .pinOeN(p7OeN),
		.pullUp(p7Pu), .extLvl(p7Ext), .extEn(p7En), .pinIn(p7In));
	gpm_pin_model #(.W(5)) u_pins12 (.clk, .pinOut(p12Out), .pinOeN(p12OeN),
		.pullUp(p12Pu), .extLvl(p12Ext), .extEn(p12En), .pinIn(p12In));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		byteWrite <= 1'h1;
		@(posedge clk);
		byteWrite <= 1'h0;
		#1;
	endtask
	task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
		@(posedge clk);
		addr <= a;
		bitSel <= s;
		bitVal <= v;
		bitWrite <= 1'h1;
		@(posedge clk);
		bitWrite <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'h1;
		@(posedge clk);
		rdEn <= 1'h0;
		#1;
		chk(rdData, exp);
	endtask
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Whole run is under a hundred cycles; this allows over forty times that
	initial begin
		#200000;
		miscompares++;
		give_verdict;
	end

	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		foreach (dirA[i]) rd(dirA[i], 8'hff);
		rd(16'hff00, 8'h00);
		rd(16'hff07, 8'h5a);
		rd(16'hff0c, 8'h0a);
		rd(16'hff01, 8'ha3);
		rd(16'hff02, 8'h3c);
		chk(p7OeN, 8'hff);
		chk({3'h0, p12OeN}, 8'h1f);
		$display("test reset done");
		bw(16'hff26, 3'h2, 1'h0);
		rd(16'hff26, 8'hfb);
		bw(16'hff2e, 3'h1, 1'h0);
		chk({6'h0, p14Dir}, 8'h01);
		rd(16'hff2e, 8'hfd);
		wr(16'hff20, 8'h00);
		rd(16'hff20, 8'h80);
		wr(16'hff00, 8'hff);
		rd(16'hff00, 8'h7f);
		wr(16'hff2c, 8'h00);
		rd(16'hff2c, 8'he0);
		// Unmapped place ignores the write and reads zero
		wr(16'hff10, 8'hff);
		rd(16'hff10, 8'h00);
		$display("test fixed bits done");
		p7En <= 8'h0f;
		p7Ext <= 8'h03;
		wr(16'hff27, 8'h0f);
		wr(16'hff07, 8'ha5);
		chk(p7OeN, 8'h0f);
		chk(p7Out, 8'ha5);
		rd(16'hff07, 8'ha3);
		$display("test port7 drive done");
		wr(16'hff37, 8'hff);
		chk(p7Pu, 8'h0f);
		p7En <= 8'h00;
		rd(16'hff07, 8'haf);
		wr(16'hff3c, 8'hff);
		chk({3'h0, p12Pu}, 8'h00);
		bw(16'hff2c, 3'h0, 1'h1);
		chk({3'h0, p12Pu}, 8'h01);
		$display("test pull-up done");
		bw(16'hff07, 3'h0, 1'h0);
		chk(p7Out, 8'hae);
		bw(16'hff27, 3'h0, 1'h0);
		chk(p7OeN, 8'h0e);
		chk(p7Pu, 8'h0e);
		rd(16'hff07, 8'hae);
		$display("test bit write done");
		wr(16'hff0c, 8'hff);
		chk({3'h0, p12Out}, 8'h1f);
		rd(16'hff0c, 8'h1e);
		@(posedge clk);
		mOsc <= 1'h1;
		mExt <= 1'h1;
		#1;
		chk({3'h0, p12OeN}, 8'h07);
		rd(16'hff0c, 8'h18);
		@(posedge clk);
		sOsc <= 1'h1;
		sExt <= 1'h1;
		rd(16'hff0c, 8'h00);
		chk({3'h0, p12OeN}, 8'h1f);
		@(posedge clk);
		{mOsc, mExt, sOsc, sExt} <= 4'h0;
		rd(16'hff0c, 8'h1e);
		$display("test clock pins done");
		@(posedge clk);
		nrst <= 1'h0;
		@(posedge clk);
		nrst <= 1'h1;
		#1;
		chk(p7OeN, 8'hff);
		chk(p7Out, 8'h00);
		chk({3'h0, p12OeN}, 8'h1f);
		chk(p7Pu, 8'h00);
		rd(16'hff27, 8'hff);
		$display("test second reset done");
		give_verdict;
	end
endmodule
